// [cbmx_core.v]
`timescale 1ns/1ps
`include "cbmx_map.vh"

module cbmx_core (
    input wire clk_i, // Core clock, 100 MHz
    input wire sys_rst_i, // Synchronous reset, active high
    output wire [15:0] code_addr_o, // Code memory address
    input wire [7:0] code_data_i, // Code byte at code_addr_o, combinational
    input wire [7:0] low_mux_port_i, // Low port pin level
    output wire [7:0] low_mux_port_o, // Low port address/data out
    output wire low_mux_port_oe_n_o, // Low port enable, low while driving
    output wire [7:0] high_address_port_o, // High address byte
    output wire addr_latch_o, // Address latch strobe, high
    output wire ext_rd_n_o, // External read strobe, low active
    output wire ext_wr_n_o, // External write strobe, low active
    output wire [7:0] acc_o, // Accumulator
    output wire [7:0] aux_o, // Aux operand register
    output wire [15:0] data_pointer_o, // Data pointer
    output wire [15:0] pc_o, // Program counter
    output wire [7:0] sp_o, // Stack pointer
    output wire carry_o, // Carry flag
    output wire product_high_o, // Product-high flag
    output wire retire_o // One-cycle pulse as an instruction ends
);
    reg [7:0] iram_q [0:255];
    reg [7:0] acc_q, aux_q, sp_q, op_q, b1_q, b2_q, hi_q, lo_out_q;
    reg [15:0] pc_q, data_pointer_q, caddr_q;
    reg cy_q, ov_q, oe_n_q, ale_q, rd_n_q, wr_n_q, retire_q;
    reg [3:0] cnt_q;
    reg [7:0] s1_q, s2_q, s3_q;

    // Bytes per opcode; unlisted opcodes (idle, 0x73, 0xA4 and others) are one byte long
    function [1:0] f_len;
        input [7:0] op;
        begin
            casez (op)
                `CBMX_OP_JBC, `CBMX_OP_LONG_SUBROUTINE_CALL, `CBMX_OP_LJUMP,
                `CBMX_OP_DIR_IMM, `CBMX_OP_DIR_DIR, `CBMX_OP_LDPTR: f_len = 2'd3;
                `CBMX_OP_JCC, `CBMX_OP_JNZ, `CBMX_OP_JZ, `CBMX_OP_ACC_IMM,
                `CBMX_OP_ACC_DIR, `CBMX_OP_DIR_ACC, `CBMX_OP_CY_BIT, `CBMX_OP_BIT_CY,
                8'b0111_011?, 8'b0111_1???, 8'b1010_011?, 8'b1010_1???,
                8'b1000_011?, 8'b1000_1???: f_len = 2'd2;
                default: f_len = 2'd1;
            endcase
        end
    endfunction

    // Machine cycles per opcode
    function [2:0] f_cyc;
        input [7:0] op;
        begin
            casez (op)
                `CBMX_OP_MUL: f_cyc = 3'd4;
                `CBMX_OP_IJMP, `CBMX_OP_JBC, `CBMX_OP_JCC, `CBMX_OP_JNZ, `CBMX_OP_JZ,
                `CBMX_OP_LONG_SUBROUTINE_CALL, `CBMX_OP_LJUMP, `CBMX_OP_BIT_CY, `CBMX_OP_DIR_IMM,
                `CBMX_OP_DIR_DIR, `CBMX_OP_LDPTR, `CBMX_OP_CODE_DP,
                8'b1010_011?, 8'b1010_1???, 8'b1000_011?, 8'b1000_1???,
                8'b111?_0000, 8'b111?_001?: f_cyc = 3'd2;
                default: f_cyc = 3'd1;
            endcase
        end
    endfunction

    // Last clock index of an instruction
    function [3:0] f_last;
        input [7:0] op;
        integer t;
        begin
            t = f_cyc(op) * `CBMX_MC_CLKS - 1;
            f_last = t[3:0];
        end
    endfunction

    // RAM byte that holds a bit address
    function [7:0] f_bit_byte;
        input [7:0] ba;
        begin
            if (ba[7]) begin
                f_bit_byte = {ba[7:3], 3'b000};
            end else begin
                f_bit_byte = `CBMX_BIT_AREA + {4'h0, ba[6:3]};
            end
        end
    endfunction

    // Signed offset from the address after the branch
    function [15:0] f_rel;
        input [15:0] pc;
        input [7:0] rel;
        begin
            f_rel = pc + {{8{rel[7]}}, rel};
        end
    endfunction

    // Operand views used by the execute step
    wire [7:0] ri_w = iram_q[{7'h00, op_q[0]}];
    wire [7:0] ind_w = iram_q[ri_w];
    wire [7:0] rn_w = iram_q[{5'h00, op_q[2:0]}];
    wire [7:0] dir_w = iram_q[b1_q];
    wire [7:0] bb_w = f_bit_byte(b1_q);
    wire [7:0] bbyte_w = iram_q[bb_w];
    wire bit_w = bbyte_w[b1_q[2:0]];
    wire [15:0] acc16_w = {8'h00, acc_q};
    wire last_w = (cnt_q == f_last(op_q)) && (cnt_q != 4'h0);
    wire exec_w = (cnt_q == `CBMX_EXEC_CNT);
    wire ext_w = (op_q[7:5] == 3'b111) && (op_q[3:2] == 2'b00) && (op_q[1:0] != 2'b01);
    wire ext_wr_w = op_q[4];
    wire ext_dp_w = ~op_q[1];
    wire mul_start_w = exec_w && (op_q == `CBMX_OP_MUL);
    wire [15:0] prod_w;
    wire mul_done_w;
    reg [7:0] bnew_r;

    // Bit write-back byte: addressed bit replaced by carry
    always @* begin
        bnew_r = bbyte_w;
        bnew_r[b1_q[2:0]] = cy_q;
    end

    cbmx_mul #(
        .WIDTH(8)
    ) u_mul (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(mul_start_w),
        .a_i(acc_q),
        .b_i(aux_q),
        .prod_o(prod_w),
        .done_o(mul_done_w)
    );

    // Three-stage pin synchroniser; only stages two and three are compared
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
        end else begin
            s1_q <= low_mux_port_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // RAM has no reset so that it maps to plain storage
    always @(posedge clk_i) begin
        if (!sys_rst_i && exec_w) begin
            casez (op_q)
                `CBMX_OP_LONG_SUBROUTINE_CALL: iram_q[sp_q + 8'h01] <= pc_q[7:0];
                8'b1111_011?: iram_q[ri_w] <= acc_q;
                8'b1111_1???: iram_q[{5'h00, op_q[2:0]}] <= acc_q;
                `CBMX_OP_DIR_ACC: iram_q[b1_q] <= acc_q;
                `CBMX_OP_BIT_CY: iram_q[bb_w] <= bnew_r;
                8'b0111_011?: iram_q[ri_w] <= b1_q;
                8'b0111_1???: iram_q[{5'h00, op_q[2:0]}] <= b1_q;
                8'b1010_011?: iram_q[ri_w] <= dir_w;
                8'b1010_1???: iram_q[{5'h00, op_q[2:0]}] <= dir_w;
                `CBMX_OP_DIR_IMM: iram_q[b1_q] <= b2_q;
                8'b1000_011?: iram_q[b1_q] <= ind_w;
                8'b1000_1???: iram_q[b1_q] <= rn_w;
                `CBMX_OP_DIR_DIR: iram_q[b2_q] <= dir_w;
                default: ;
            endcase
        end else if (!sys_rst_i && cnt_q == 4'h4 && op_q == `CBMX_OP_LONG_SUBROUTINE_CALL) begin
            iram_q[sp_q + 8'h01] <= pc_q[15:8];
        end
    end

    // Sequencer: fetch in clocks 0-2, execute in clock 3, finish at the last clock
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 4'h0;
            op_q <= `CBMX_OP_IDLE;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            pc_q <= `CBMX_PC_RST;
            caddr_q <= `CBMX_PC_RST;
            acc_q <= 8'h00;
            aux_q <= 8'h00;
            data_pointer_q <= 16'h0000;
            sp_q <= `CBMX_SP_RST;
            cy_q <= 1'b0;
            ov_q <= 1'b0;
            retire_q <= 1'b0;
        end else begin
            retire_q <= last_w;
            cnt_q <= last_w ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h0) begin
                op_q <= code_data_i;
                pc_q <= pc_q + 16'h0001;
                caddr_q <= pc_q + 16'h0001;
            end else if (cnt_q == 4'h1) begin
                if (f_len(op_q) != 2'd1) begin
                    b1_q <= code_data_i;
                    pc_q <= pc_q + 16'h0001;
                    caddr_q <= pc_q + 16'h0001;
                end else if (op_q == `CBMX_OP_CODE_PC) begin
                    caddr_q <= pc_q + acc16_w;
                end else if (op_q == `CBMX_OP_CODE_DP) begin
                    caddr_q <= data_pointer_q + acc16_w;
                end
            end else if (cnt_q == 4'h2) begin
                if (f_len(op_q) == 2'd3) begin
                    b2_q <= code_data_i;
                    pc_q <= pc_q + 16'h0001;
                    caddr_q <= pc_q + 16'h0001;
                end else if (op_q == `CBMX_OP_CODE_PC || op_q == `CBMX_OP_CODE_DP) begin
                    acc_q <= code_data_i;
                    caddr_q <= pc_q;
                end
            end else if (exec_w) begin
                casez (op_q)
                    `CBMX_OP_IJMP: begin
                        pc_q <= data_pointer_q + acc16_w;
                        caddr_q <= data_pointer_q + acc16_w;
                    end
                    `CBMX_OP_JBC: begin
                        if (!bit_w) begin
                            pc_q <= f_rel(pc_q, b2_q);
                            caddr_q <= f_rel(pc_q, b2_q);
                        end
                    end
                    `CBMX_OP_JCC: begin
                        if (!cy_q) begin
                            pc_q <= f_rel(pc_q, b1_q);
                            caddr_q <= f_rel(pc_q, b1_q);
                        end
                    end
                    `CBMX_OP_JNZ: begin
                        if (acc_q != 8'h00) begin
                            pc_q <= f_rel(pc_q, b1_q);
                            caddr_q <= f_rel(pc_q, b1_q);
                        end
                    end
                    `CBMX_OP_JZ: begin
                        if (acc_q == 8'h00) begin
                            pc_q <= f_rel(pc_q, b1_q);
                            caddr_q <= f_rel(pc_q, b1_q);
                        end
                    end
                    `CBMX_OP_LONG_SUBROUTINE_CALL: sp_q <= sp_q + 8'h01;
                    `CBMX_OP_LJUMP: begin
                        pc_q <= {b1_q, b2_q};
                        caddr_q <= {b1_q, b2_q};
                    end
                    `CBMX_OP_ACC_IMM: acc_q <= b1_q;
                    8'b1110_011?: acc_q <= ind_w;
                    8'b1110_1???: acc_q <= rn_w;
                    `CBMX_OP_ACC_DIR: acc_q <= dir_w;
                    `CBMX_OP_CY_BIT: cy_q <= bit_w;
                    `CBMX_OP_LDPTR: data_pointer_q <= {b1_q, b2_q};
                    default: ;
                endcase
            end else if (cnt_q == 4'h4 && op_q == `CBMX_OP_LONG_SUBROUTINE_CALL) begin
                // Counter already points past the call: that is the return address
                sp_q <= sp_q + 8'h01;
                pc_q <= {b1_q, b2_q};
                caddr_q <= {b1_q, b2_q};
            end else if (last_w && op_q == `CBMX_OP_MUL && mul_done_w) begin
                acc_q <= prod_w[7:0];
                aux_q <= prod_w[15:8];
                cy_q <= 1'b0;
                ov_q <= (prod_w[15:8] != 8'h00);
            end else if (last_w && ext_w && !ext_wr_w && s2_q == s3_q) begin
                // A value still settling is dropped rather than half-read
                acc_q <= s3_q;
            end
        end
    end

    // External transfer strobes: address in clock 3, strobe from clock 4 to the end.
    // Read data must stand for the first two strobe clocks so stages two and three of the synchroniser agree by the last edge.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            hi_q <= `CBMX_HI_PORT_RST;
            lo_out_q <= 8'h00;
            oe_n_q <= 1'b1;
            ale_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (ext_w && cnt_q == 4'h2) begin
            ale_q <= 1'b1;
            oe_n_q <= 1'b0;
            if (ext_dp_w) begin
                lo_out_q <= data_pointer_q[7:0];
                hi_q <= data_pointer_q[15:8];
            end else begin
                lo_out_q <= ri_w;
            end
        end else if (ext_w && exec_w) begin
            ale_q <= 1'b0;
            if (ext_wr_w) begin
                lo_out_q <= acc_q;
                wr_n_q <= 1'b0;
            end else begin
                oe_n_q <= 1'b1; // Release the port so memory can drive it
                rd_n_q <= 1'b0;
            end
        end else if (last_w) begin
            oe_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end
    end

    assign code_addr_o = caddr_q;
    assign low_mux_port_o = lo_out_q;
    assign low_mux_port_oe_n_o = oe_n_q;
    assign high_address_port_o = hi_q;
    assign addr_latch_o = ale_q;
    assign ext_rd_n_o = rd_n_q;
    assign ext_wr_n_o = wr_n_q;
    assign acc_o = acc_q;
    assign aux_o = aux_q;
    assign data_pointer_o = data_pointer_q;
    assign pc_o = pc_q;
    assign sp_o = sp_q;
    assign carry_o = cy_q;
    assign product_high_o = ov_q;
    assign retire_o = retire_q;
endmodule // cbmx_core

// [cbmx_map.vh]
// What this block does
// - Opcode 0x73 jumps to data pointer plus accumulator, two cycles, no flags.
// - Three-byte 0x30 branches relative when the addressed bit is zero.
// - Two-byte 0x50 branches relative only when carry is zero.
// - Two-byte 0x70 branches relative when accumulator is nonzero.
// - Two-byte 0x60 branches relative only when accumulator is zero.
// - Call 0x12 pushes counter plus 3, low byte first, then loads target.
// - Three-byte 0x02 loads the counter with the 16-bit target.
// - Accumulator copies 0x74, E5-EF and F5-FF, one cycle, no flags.
// - 0xA2 copies a bit into carry; 0x92 copies carry into a bit.
// - RAM copies: 76-7F one cycle; A6-AF, 86-8F two; 0x75 three bytes.
// - For 0x85 the second byte is source, third byte destination.
// - Three-byte 0x90 loads the data pointer with its immediate word.
// - 0x93 reads code at accumulator plus data pointer into accumulator.
// - 0x83 advances counter by 1, reads code at counter plus accumulator.
// - 0xF0/0xE0 put a 16-bit address on both low and high ports.
// - 0xF2-F3/0xE2-E3 use only the low port; high port keeps its value.
// - 0xA4 multiplies accumulator by aux register; low to acc, high to aux.
// - Multiply clears carry; product-high flag set when high byte nonzero.
// - 0x00 takes one machine cycle and changes nothing.
// - Relative offset is signed -128..+127 from the following instruction.
`ifndef CBMX_MAP_VH
`define CBMX_MAP_VH

// Clocks per machine cycle and the clock index of the execute step
`define CBMX_MC_CLKS 4
`define CBMX_EXEC_CNT 4'h3

// Reset values
`define CBMX_SP_RST 8'h07
`define CBMX_HI_PORT_RST 8'h00
`define CBMX_PC_RST 16'h0000

// Opcodes handled as single codes
`define CBMX_OP_IDLE 8'h00
`define CBMX_OP_LJUMP 8'h02
`define CBMX_OP_LONG_SUBROUTINE_CALL 8'h12
`define CBMX_OP_JBC 8'h30
`define CBMX_OP_JCC 8'h50
`define CBMX_OP_JZ 8'h60
`define CBMX_OP_JNZ 8'h70
`define CBMX_OP_IJMP 8'h73
`define CBMX_OP_ACC_IMM 8'h74
`define CBMX_OP_DIR_IMM 8'h75
`define CBMX_OP_CODE_PC 8'h83
`define CBMX_OP_DIR_DIR 8'h85
`define CBMX_OP_LDPTR 8'h90
`define CBMX_OP_BIT_CY 8'h92
`define CBMX_OP_CODE_DP 8'h93
`define CBMX_OP_CY_BIT 8'hA2
`define CBMX_OP_MUL 8'hA4
`define CBMX_OP_ACC_DIR 8'hE5
`define CBMX_OP_DIR_ACC 8'hF5

// Base byte of the bit-addressable RAM area that holds bit addresses below 0x80
`define CBMX_BIT_AREA 8'h20

`endif

// [cbmx_mul.v]
`timescale 1ns/1ps
`include "cbmx_map.vh"

module cbmx_mul #(
    parameter WIDTH = 8
) (
    input wire clk_i, // Core clock
    input wire sys_rst_i, // Synchronous reset, active high
    input wire start_i, // One-cycle start pulse
    input wire [WIDTH-1:0] a_i, // Multiplicand
    input wire [WIDTH-1:0] b_i, // Multiplier
    output wire [2*WIDTH-1:0] prod_o, // Product, valid once done
    output wire done_o // High when idle with a result
);
    reg [2*WIDTH-1:0] acc_q;
    reg [2*WIDTH-1:0] mcand_q;
    reg [WIDTH-1:0] mplier_q;
    reg [4:0] left_q;

    // Shift-add, one bit per clock; slower than a flat array but tiny
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_q <= {2*WIDTH{1'b0}};
            mcand_q <= {2*WIDTH{1'b0}};
            mplier_q <= {WIDTH{1'b0}};
            left_q <= 5'h00;
        end else if (start_i) begin
            acc_q <= {2*WIDTH{1'b0}};
            mcand_q <= {{WIDTH{1'b0}}, a_i};
            mplier_q <= b_i;
            left_q <= WIDTH[4:0];
        end else if (left_q != 5'h00) begin
            if (mplier_q[0]) begin
                acc_q <= acc_q + mcand_q;
            end
            mcand_q <= {mcand_q[2*WIDTH-2:0], 1'b0};
            mplier_q <= {1'b0, mplier_q[WIDTH-1:1]};
            left_q <= left_q - 5'h01;
        end
    end

    assign prod_o = acc_q;
    assign done_o = (left_q == 5'h00);
endmodule // cbmx_mul

// [cbmx_core_asserts.sv]
`timescale 1ns/1ps
`include "cbmx_map.vh"

module cbmx_core_chk (
    input wire clk_i, // Core clock
    input wire sys_rst_i, // Synchronous reset
    input wire [15:0] code_addr_o, // Code address
    input wire [7:0] code_data_i, // Code byte
    input wire [7:0] low_mux_port_o, // Low port out
    input wire low_mux_port_oe_n_o, // Low port enable
    input wire [7:0] high_address_port_o, // High address byte
    input wire addr_latch_o, // Address strobe
    input wire ext_wr_n_o, // Write strobe
    input wire [7:0] acc_o, // Accumulator
    input wire [7:0] aux_o, // Aux register
    input wire [15:0] data_pointer_o, // Data pointer
    input wire [15:0] pc_o, // Program counter
    input wire [7:0] sp_o, // Stack pointer
    input wire carry_o, // Carry flag
    input wire product_high_o, // Product-high flag
    input wire retire_o // Instruction end
);
    logic [7:0] op_q, b1_q, b2_q, acc_q, aux_q, sp_q;
    logic [15:0] pc_q, dp_q, a2_q;
    logic [4:0] n_q;
    logic cy_q, v_q, first_q;
    wire st = retire_o || first_q;
    wire done = retire_o && v_q;
    wire [15:0] rel = {{8{b1_q[7]}}, b1_q};

    // Snapshot per instruction; the opcode sits on the code port in the retire cycle
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            first_q <= 1'b1;
            v_q <= 1'b0;
            n_q <= 5'h00;
        end else begin
            first_q <= 1'b0;
            n_q <= st ? 5'h01 : n_q + 5'h01;
            if (st) begin
                v_q <= 1'b1;
                {op_q, acc_q, aux_q, sp_q, cy_q, pc_q, dp_q} <= {code_data_i, acc_o, aux_o, sp_o, carry_o, pc_o, data_pointer_o};
            end
            if (n_q == 5'h01) b1_q <= code_data_i;
            if (n_q == 5'h02) {b2_q, a2_q} <= {code_data_i, code_addr_o};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // External write: address phase, then four strobe clocks carrying the accumulator
    sequence s_addr_out;
        addr_latch_o && !low_mux_port_oe_n_o && {high_address_port_o, low_mux_port_o} == data_pointer_o;
    endsequence
    sequence s_wr_strobe;
        (!ext_wr_n_o && !low_mux_port_oe_n_o && low_mux_port_o == acc_o)[*4] ##1 ext_wr_n_o;
    endsequence
    sequence s_hi_hold;
        $stable(high_address_port_o)[*8];
    endsequence

    idle_keep_a: assert property (done && op_q == `CBMX_OP_IDLE |-> n_q == 5'h04 && pc_o == pc_q + 16'h0001
        && {acc_o, aux_o, sp_o, data_pointer_o, carry_o} == {acc_q, aux_q, sp_q, dp_q, cy_q}) else $error("idle changed state");
    mul_result_a: assert property (done && op_q == `CBMX_OP_MUL |-> n_q == 5'h10 && !carry_o
        && {aux_o, acc_o} == {8'h00, acc_q} * {8'h00, aux_q} && product_high_o == (aux_o != 8'h00)) else $error("bad mul");
    ijmp_sum_a: assert property (done && op_q == `CBMX_OP_IJMP |-> n_q == 5'h08 && pc_o == dp_q + {8'h00, acc_q})
        else $error("indexed jump target wrong");
    long_jump_target_a: assert property (done && op_q == `CBMX_OP_LJUMP |-> n_q == 5'h08 && pc_o == {b1_q, b2_q})
        else $error("long jump target wrong");
    call_target_a: assert property (done && op_q == `CBMX_OP_LONG_SUBROUTINE_CALL |-> pc_o == {b1_q, b2_q} && sp_o == sp_q + 8'h02)
        else $error("call target or stack wrong");
    ldptr_word_a: assert property (done && op_q == `CBMX_OP_LDPTR |-> n_q == 5'h08 && data_pointer_o == {b1_q, b2_q})
        else $error("pointer load wrong");
    zero_branch_a: assert property (done && op_q == `CBMX_OP_JZ |-> n_q == 5'h08
        && pc_o == pc_q + 16'h0002 + (acc_q == 8'h00 ? rel : 16'h0000)) else $error("zero branch wrong");
    carry_branch_a: assert property (done && op_q == `CBMX_OP_JCC |-> n_q == 5'h08
        && pc_o == pc_q + 16'h0002 + (cy_q ? 16'h0000 : rel)) else $error("carry branch wrong");
    code_ptr_a: assert property (done && op_q == `CBMX_OP_CODE_DP |-> n_q == 5'h08
        && a2_q == dp_q + {8'h00, acc_q} && acc_o == b2_q) else $error("pointer code read wrong");
    ext_write_a: assert property (st && code_data_i == 8'hF0 |-> ##3 s_addr_out ##1 s_wr_strobe)
        else $error("external write cycle wrong");
    hi_port_hold_a: assert property (st && code_data_i inside {8'hE2, 8'hE3, 8'hF2, 8'hF3} |-> ##1 s_hi_hold)
        else $error("high port moved");
endmodule // cbmx_core_chk

// [cbmx_xmem.sv]
`timescale 1ns/1ps

module cbmx_xmem (
    input wire clk_i, // Core clock
    input wire [7:0] low_i, // Low port as driven by the core
    input wire [7:0] high_i, // High address byte
    input wire ale_i, // Address latch strobe
    input wire rd_n_i, // Read strobe, low active
    input wire wr_n_i, // Write strobe, low active
    output wire [7:0] dat_o // Byte this memory offers the low port
);
    logic [7:0] mem [0:65535];
    logic [15:0] adr_q;
    logic [7:0] last_q = 8'h00;

    // High byte is whatever the high port holds, so 8-bit forms reuse the old page
    always @(posedge clk_i) begin
        if (ale_i) adr_q <= {high_i, low_i};
        if (!wr_n_i) mem[adr_q] <= low_i;
        if (!rd_n_i) last_q <= mem[adr_q];
    end
    // Released bus shows the inverse of the last byte so a stale value never passes
    assign dat_o = rd_n_i ? ~last_q : mem[adr_q];
endmodule // cbmx_xmem

// [cbmx_core_tb_top.sv]
`timescale 1ns/1ps

module cbmx_core_tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] rom [0:65535];
    wire [15:0] code_addr_o, data_pointer_o, pc_o;
    wire [7:0] low_mux_port_o, high_address_port_o, acc_o, aux_o, sp_o, mem_dat;
    wire low_mux_port_oe_n_o, addr_latch_o, ext_rd_n_o, ext_wr_n_o, carry_o, product_high_o, retire_o;
    // Code memory answers in the same cycle; the pin merges core and memory drive
    wire [7:0] code_data_i = rom[code_addr_o];
    wire [7:0] low_mux_port_i = low_mux_port_oe_n_o ? mem_dat : low_mux_port_o;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;

    cbmx_core i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .code_addr_o(code_addr_o), .code_data_i(code_data_i),
        .low_mux_port_i(low_mux_port_i), .low_mux_port_o(low_mux_port_o), .low_mux_port_oe_n_o(low_mux_port_oe_n_o),
        .high_address_port_o(high_address_port_o), .addr_latch_o(addr_latch_o), .ext_rd_n_o(ext_rd_n_o),
        .ext_wr_n_o(ext_wr_n_o), .acc_o(acc_o), .aux_o(aux_o), .data_pointer_o(data_pointer_o), .pc_o(pc_o), .sp_o(sp_o),
        .carry_o(carry_o), .product_high_o(product_high_o), .retire_o(retire_o));
    cbmx_xmem i_mem (.clk_i(clk_i), .low_i(low_mux_port_o), .high_i(high_address_port_o), .ale_i(addr_latch_o),
        .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .dat_o(mem_dat));

    // Core clock
    initial forever #5 clk_i = ~clk_i;
    // A stalled instruction stream ends the run well past the expected length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] p[$]);
        foreach (p[i]) rom[a + 16'(i)] = p[i];
    endtask
    // Program is loaded while the core is held in reset
    task automatic clr();
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        rom = '{default: 8'h00};
    endtask
    task automatic go();
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
    endtask
    // Waits for n retire pulses, each bounded
    task automatic run(input int n);
        int k;
        repeat (n) begin
            k = 0;
            @(negedge clk_i);
            while (retire_o !== 1'b1 && k < 20) begin
                @(negedge clk_i);
                k++;
            end
            if (k == 20) chk("retire", 32'h0, 32'h1);
        end
    endtask
    task automatic step(input int n, input logic [31:0] e);
        run(n);
        chk("acc pc", {8'h00, acc_o, pc_o}, e);
    endtask

    task automatic t_idle();
        repeat (10) @(negedge clk_i);
        chk("reset", {sp_o, high_address_port_o, pc_o}, 32'h0700_0000);
        chk("pins", {25'h0, low_mux_port_oe_n_o, ext_rd_n_o, ext_wr_n_o, addr_latch_o, carry_o,
            product_high_o, retire_o}, 32'h70);
        sys_rst_i = 1'b0;
        step(2, 32'h0000_0002);
        chk("sp data_pointer", {8'h00, sp_o, data_pointer_o}, 32'h0007_0000);
    endtask
    task automatic t_copy();
        clr();
        prog(16'h0000, {8'h74, 8'h5A, 8'hF5, 8'h30, 8'h85, 8'h30, 8'h33, 8'h74, 8'h00, 8'hE5, 8'h33, 8'h75, 8'h32,
            8'hC3, 8'hE5, 8'h32, 8'h78, 8'h40, 8'hF6, 8'h74, 8'h00, 8'h79, 8'h40, 8'hE7});
        go();
        step(5, 32'h005A_000B);
        step(2, 32'h00C3_0010);
        step(5, 32'h00C3_0018);
    endtask
    // Aux only changes through multiply and starts at zero, so the high product stays zero here
    task automatic t_flags();
        clr();
        prog(16'h0000, {8'h75, 8'h20, 8'h01, 8'hA2, 8'h00, 8'h92, 8'h01, 8'h50, 8'h80, 8'hE5, 8'h20, 8'h70, 8'h01,
            8'h00, 8'hA4, 8'h50, 8'hFE});
        go();
        step(5, 32'h0003_000B);
        chk("carry", {31'h0, carry_o}, 32'h1);
        step(1, 32'h0003_000E);
        step(1, 32'h0000_000F);
        chk("aux flags", {22'h0, aux_o, carry_o, product_high_o}, 32'h0);
        step(1, 32'h0000_000F);
    endtask
    task automatic t_branch();
        clr();
        prog(16'h0000, {8'h75, 8'h20, 8'h00, 8'h60, 8'h02, 8'h00, 8'h00, 8'h70, 8'h7F, 8'h30, 8'h00, 8'hF4});
        go();
        step(1, 32'h0000_0003);
        step(1, 32'h0000_0007);
        step(1, 32'h0000_0009);
        step(1, 32'h0000_0000);
    endtask
    task automatic t_flow();
        clr();
        prog(16'h0000, {8'h90, 8'hFF, 8'hF0, 8'h74, 8'h20, 8'h73});
        prog(16'h0010, {8'h12, 8'h12, 8'h34});
        prog(16'h1234, {8'h02, 8'h00, 8'h40});
        prog(16'h0040, {8'h93, 8'h83, 8'hE5, 8'h08, 8'hE5, 8'h09});
        prog(16'h0054, {8'h77});
        go();
        step(3, 32'h0020_0010);
        chk("data_pointer", {16'h0, data_pointer_o}, 32'h0000_FFF0);
        step(1, 32'h0020_1234);
        chk("sp", {24'h0, sp_o}, 32'h09);
        step(1, 32'h0020_0040);
        step(1, 32'h0012_0041);
        step(1, 32'h0077_0042);
        step(1, 32'h0013_0044);
        step(1, 32'h0000_0046);
    endtask
    task automatic t_ext();
        clr();
        prog(16'h0000, {8'h90, 8'h12, 8'h34, 8'h74, 8'hA5, 8'hF0, 8'h78, 8'h56, 8'h74, 8'h3C, 8'hF2, 8'hE0, 8'hE2});
        go();
        step(3, 32'h00A5_0006);
        chk("xmem", {16'h0, i_mem.mem[16'h1234], high_address_port_o}, 32'h0000_A512);
        step(3, 32'h003C_000B);
        chk("xmem", {16'h0, i_mem.mem[16'h1256], high_address_port_o}, 32'h0000_3C12);
        step(1, 32'h00A5_000C);
        step(1, 32'h003C_000D);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        rom = '{default: 8'h00};
        t_idle();
        t_copy();
        t_flags();
        t_branch();
        t_flow();
        t_ext();
        wrap_up();
    end
endmodule // cbmx_core_tb_top

bind cbmx_core cbmx_core_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .code_addr_o(code_addr_o),
    .code_data_i(code_data_i), .low_mux_port_o(low_mux_port_o), .low_mux_port_oe_n_o(low_mux_port_oe_n_o),
    .high_address_port_o(high_address_port_o), .addr_latch_o(addr_latch_o), .ext_wr_n_o(ext_wr_n_o),
    .acc_o(acc_o), .aux_o(aux_o), .data_pointer_o(data_pointer_o), .pc_o(pc_o), .sp_o(sp_o), .carry_o(carry_o),
    .product_high_o(product_high_o), .retire_o(retire_o));
